// >>> pdoc_pkg.sv
`default_nettype none
package pdoc_pkg;
   // configuration byte field positions
   localparam int CFG_INV_BIT = 7;
   localparam int CFG_DET_BIT = 6;
   localparam int CFG_LDE_BIT = 5;
   localparam int CFG_DIV_HI = 4;
   localparam int CFG_DIV_LO = 2;
   localparam int CFG_FVE_BIT = 1;
   localparam int CFG_FRE_BIT = 0;
   // value after reset: divide-by-8 select, everything else low
   localparam logic [7:0] CFG_RESET = 8'h10;
   // frame lengths in serial clocks
   localparam logic [4:0] FRAME_CFG = 5'h08;
   localparam logic [4:0] FRAME_OSC = 5'h10;
   localparam logic [4:0] FRAME_REF_MIN = 5'h0F;
   localparam logic [4:0] FRAME_MAX = 5'h18;
   // reset value of the divider registers
   localparam logic [15:0] NDIV_RESET = 16'h0028;
   localparam logic [14:0] RDIV_RESET = 15'h0005;
   // minimum width of the both-low pulse, in mclk cycles
   localparam logic [1:0] MIN_PULSE = 2'h2;
   // reference-output select encodings
   localparam logic [2:0] REFSEL_OFF = 3'h0;
   localparam logic [2:0] REFSEL_DIV1 = 3'h1;
   localparam logic [2:0] REFSEL_DIV2 = 3'h2;
   localparam logic [2:0] REFSEL_DIV4 = 3'h3;
   localparam logic [2:0] REFSEL_DIV8A = 3'h4;
   localparam logic [2:0] REFSEL_DIV16A = 3'h5;
   localparam logic [2:0] REFSEL_DIV8B = 3'h6;
   localparam logic [2:0] REFSEL_DIV16B = 3'h7;
   typedef enum logic [1:0] {SP_IDLE, SP_SHIFT} pdoc_sp_state_t;
endpackage : pdoc_pkg
`default_nettype wire

// >>> pdoc_sync.sv
`default_nettype none
module pdoc_sync (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // asynchronous level in, clean level and edges out
   input wire logic async_in,
   output logic level_out,
   output logic rise_out,
   output logic fall_out
);
   import pdoc_pkg::*;
   typedef struct packed {
      logic [2:0] sh;
      logic lvl;
      logic rise;
      logic fall;
   } pdoc_sync_t;
   pdoc_sync_t s_reg, s_next;

   always_comb begin
      s_next = s_reg;
      s_next.sh = {s_reg.sh[1:0], async_in};
      s_next.rise = 1'b0;
      s_next.fall = 1'b0;
      // stage 0 is only read by stage 1; a change counts when stages 1 and 2 agree
      if (s_reg.sh[2] == s_reg.sh[1] && s_reg.sh[2] != s_reg.lvl) begin
         s_next.lvl = s_reg.sh[2];
         s_next.rise = s_reg.sh[2];
         s_next.fall = ~s_reg.sh[2];
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign level_out = s_reg.lvl;
   assign rise_out = s_reg.rise;
   assign fall_out = s_reg.fall;
endmodule : pdoc_sync
`default_nettype wire

// >>> pdoc_top.sv
`default_nettype none
module pdoc_top (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // serial port
   input wire logic serial_clk,
   input wire logic serial_data,
   input wire logic serial_select_n,
   // frequency inputs
   input wire logic crystal_clock_input,
   input wire logic loop_freq_in,
   // single-ended detector, three-state
   output logic single_ended_error_out,
   output logic single_ended_error_oe,
   // double-ended detector
   output logic pair_ref_n,
   output logic pair_osc_n,
   // lock and monitors
   output logic lock_indicator,
   output logic reference_output,
   output logic loop_divided_out,
   output logic reference_divided_out,
   // programmed dividers, for observation
   output logic [15:0] osc_divide_value,
   output logic [14:0] ref_divide_value
);
   import pdoc_pkg::*;

   // ==========================================================
   // input conditioning
   logic sclk_lvl, sclk_rise, sel_lvl, sel_rise, sel_fall, xtal_lvl, xtal_rise;
   logic fin_lvl, fin_rise, din_lvl;

   pdoc_sync u_sclk (.mclk(mclk), .sys_rst(sys_rst), .async_in(serial_clk),
      .level_out(sclk_lvl), .rise_out(sclk_rise), .fall_out());
   pdoc_sync u_sel (.mclk(mclk), .sys_rst(sys_rst), .async_in(serial_select_n),
      .level_out(sel_lvl), .rise_out(sel_rise), .fall_out(sel_fall));
   pdoc_sync u_xtal (.mclk(mclk), .sys_rst(sys_rst), .async_in(crystal_clock_input),
      .level_out(xtal_lvl), .rise_out(xtal_rise), .fall_out());
   pdoc_sync u_fin (.mclk(mclk), .sys_rst(sys_rst), .async_in(loop_freq_in),
      .level_out(fin_lvl), .rise_out(fin_rise), .fall_out());
   pdoc_sync u_din (.mclk(mclk), .sys_rst(sys_rst), .async_in(serial_data),
      .level_out(din_lvl), .rise_out(), .fall_out());

   // ==========================================================
   // state
   typedef struct packed {
      pdoc_sp_state_t sp;
      logic [23:0] shift;
      logic [4:0] count;
      logic [7:0] cfg;
      logic [15:0] ndiv;
      logic [14:0] rdiv;
      logic [15:0] ncnt;
      logic [14:0] rcnt;
      logic fv_pulse;
      logic fr_pulse;
      logic up;
      logic dn;
      logic [1:0] both_cnt;
      logic [3:0] xdiv;
      logic refo;
      logic fv_mon;
      logic fr_mon;
      logic se_out;
      logic se_oe;
      logic pr_n;
      logic pv_n;
      logic ld;
   } pdoc_state_t;
   pdoc_state_t s_reg, s_next;

   logic ref_sel_bit;
   logic [2:0] dsel;
   logic hit_v, hit_r;

   always_comb begin
      s_next = s_reg;
      dsel = s_reg.cfg[CFG_DIV_HI:CFG_DIV_LO];
      hit_v = 1'b0;
      hit_r = 1'b0;
      s_next.fv_pulse = 1'b0;
      s_next.fr_pulse = 1'b0;

      // ======================================================
      // serial port: shift on serial clock rise while selected
      case (s_reg.sp)
         SP_IDLE: begin
            s_next.count = '0;
            if (sel_fall) begin
               s_next.sp = SP_SHIFT;
            end
         end
         SP_SHIFT: begin
            if (sclk_rise && s_reg.count != FRAME_MAX) begin
               s_next.shift = {s_reg.shift[22:0], din_lvl};
               s_next.count = s_reg.count + 5'h01;
            end
            // config is untouched until the select edge closes the frame
            if (sel_rise) begin
               s_next.sp = SP_IDLE;
               if (s_reg.count == FRAME_CFG) begin
                  s_next.cfg = s_reg.shift[7:0];
               end else if (s_reg.count == FRAME_OSC) begin
                  s_next.ndiv = s_reg.shift[15:0];
                  s_next.ncnt = s_reg.shift[15:0];
                  s_next.rcnt = s_reg.rdiv;
                  s_next.up = 1'b0;
                  s_next.dn = 1'b0;
               end else if (s_reg.count >= FRAME_REF_MIN) begin
                  // fifteen or seventeen to twenty-four clocks: low 15 bits
                  s_next.rdiv = s_reg.shift[14:0];
               end
            end
         end
         default: s_next.sp = SP_IDLE;
      endcase

      // ======================================================
      // counters: one output pulse per terminal count
      if (fin_rise && !(sel_rise && s_reg.count == FRAME_OSC)) begin
         if (s_reg.ncnt <= 16'h0001) begin
            s_next.ncnt = s_reg.ndiv;
            hit_v = 1'b1;
         end else begin
            s_next.ncnt = s_reg.ncnt - 16'h0001;
         end
      end
      if (xtal_rise && !(sel_rise && s_reg.count == FRAME_OSC)) begin
         if (s_reg.rcnt <= 15'h0001) begin
            s_next.rcnt = s_reg.rdiv;
            hit_r = 1'b1;
         end else begin
            s_next.rcnt = s_reg.rcnt - 15'h0001;
         end
      end
      s_next.fv_pulse = hit_v;
      s_next.fr_pulse = hit_r;

      // ======================================================
      // phase/frequency detector on rising edges
      if (!(sel_rise && s_reg.count == FRAME_OSC)) begin
         if (s_reg.both_cnt != 2'h0) begin
            // both sides held low for a minimum width, then released
            s_next.both_cnt = s_reg.both_cnt - 2'h1;
            if (s_reg.both_cnt == 2'h1) begin
               s_next.up = 1'b0;
               s_next.dn = 1'b0;
            end
         end else begin
            if (s_reg.fv_pulse) s_next.dn = 1'b1;
            if (s_reg.fr_pulse) s_next.up = 1'b1;
            if ((s_reg.fv_pulse || s_reg.dn) && (s_reg.fr_pulse || s_reg.up)) begin
               s_next.up = 1'b1;
               s_next.dn = 1'b1;
               s_next.both_cnt = MIN_PULSE;
            end
         end
      end

      // ======================================================
      // outputs: polarity, detector choice, lock indicator
      // dn means oscillator leads up means it lags
      if (s_reg.cfg[CFG_DET_BIT]) begin
         s_next.pr_n = 1'b1;
         s_next.pv_n = 1'b1;
         // both on means the in-phase overlap; left floating
         s_next.se_oe = s_reg.up ^ s_reg.dn;
         s_next.se_out = s_reg.up ^ s_reg.cfg[CFG_INV_BIT];
      end else begin
         s_next.se_oe = 1'b0;
         s_next.se_out = 1'b0;
         if (s_reg.cfg[CFG_INV_BIT]) begin
            s_next.pr_n = ~s_reg.dn;
            s_next.pv_n = ~s_reg.up;
         end else begin
            s_next.pr_n = ~s_reg.up;
            s_next.pv_n = ~s_reg.dn;
         end
      end
      // low while only one side is active, i.e. on mismatch
      s_next.ld = s_reg.cfg[CFG_LDE_BIT] & ~(s_reg.up ^ s_reg.dn);

      // ======================================================
      // reference output divider, on crystal edges
      if (xtal_rise) begin
         s_next.xdiv = s_reg.xdiv + 4'h1;
      end
      case (dsel)
         REFSEL_OFF: ref_sel_bit = 1'b0;
         REFSEL_DIV1: ref_sel_bit = xtal_lvl;
         REFSEL_DIV2: ref_sel_bit = s_reg.xdiv[0];
         REFSEL_DIV4: ref_sel_bit = s_reg.xdiv[1];
         REFSEL_DIV8A, REFSEL_DIV8B: ref_sel_bit = s_reg.xdiv[2];
         REFSEL_DIV16A, REFSEL_DIV16B: ref_sel_bit = s_reg.xdiv[3];
         default: ref_sel_bit = 1'b0;
      endcase
      s_next.refo = ref_sel_bit;
      s_next.fv_mon = s_reg.cfg[CFG_FVE_BIT] & hit_v;
      s_next.fr_mon = s_reg.cfg[CFG_FRE_BIT] & hit_r;
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         s_reg <= '0;
         s_reg.sp <= SP_IDLE;
         s_reg.cfg <= CFG_RESET;
         s_reg.ndiv <= NDIV_RESET;
         s_reg.rdiv <= RDIV_RESET;
         s_reg.ncnt <= NDIV_RESET;
         s_reg.rcnt <= RDIV_RESET;
         s_reg.pr_n <= 1'b1;
         s_reg.pv_n <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   // fin_lvl, sclk_lvl and sel_lvl kept for observation only through the edges
   logic unused_lvls;
   assign unused_lvls = fin_lvl ^ sclk_lvl ^ sel_lvl;

   assign single_ended_error_out = s_reg.se_out;
   assign single_ended_error_oe = s_reg.se_oe;
   assign pair_ref_n = s_reg.pr_n;
   assign pair_osc_n = s_reg.pv_n;
   assign lock_indicator = s_reg.ld;
   assign reference_output = s_reg.refo;
   assign loop_divided_out = s_reg.fv_mon;
   assign reference_divided_out = s_reg.fr_mon;
   assign osc_divide_value = s_reg.ndiv;
   assign ref_divide_value = s_reg.rdiv;
endmodule : pdoc_top
`default_nettype wire

// >>> pdoc_monitor.sv
`default_nettype none
module pdoc_monitor (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // watched pins
   input wire logic serial_select_n,
   input wire logic single_ended_error_oe,
   input wire logic pair_ref_n,
   input wire logic pair_osc_n,
   input wire logic lock_indicator,
   input wire logic loop_divided_out,
   input wire logic [15:0] osc_divide_value,
   input wire logic [14:0] ref_divide_value
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   wire logic both_lo = !pair_ref_n && !pair_osc_n;
   // ==========================================
   // properties
   property p_rst;
      $past(sys_rst) |-> osc_divide_value == 16'h0028 && ref_divide_value == 15'h0005
         && !lock_indicator && !single_ended_error_oe && !loop_divided_out;
   endproperty
   property p_pick;
      single_ended_error_oe |-> pair_ref_n && pair_osc_n;
   endproperty
   property p_overlap;
      $rose(both_lo) |-> both_lo [*2] ##[1:4] !both_lo;
   endproperty
   property p_ld;
      (pair_ref_n ^ pair_osc_n) [*3] |-> ##[0:2] !lock_indicator;
   endproperty
   property p_float;
      $rose(single_ended_error_oe) |-> ##[1:1000] !single_ended_error_oe;
   endproperty
   property p_mon;
      loop_divided_out |=> !loop_divided_out;
   endproperty
   // the synchroniser delays the frame end, so only a long-low select is judged
   property p_hold;
      !serial_select_n && !$past(serial_select_n, 6) |-> $stable(osc_divide_value);
   endproperty
   property p_ref_only;
      $changed(ref_divide_value) |-> $stable(osc_divide_value);
   endproperty
   a_rst: assert property (p_rst) else $error("reset values wrong");
   a_pick: assert property (p_pick) else $error("pair active with single");
   a_overlap: assert property (p_overlap) else $error("overlap width wrong");
   a_ld: assert property (p_ld) else $error("lock high on mismatch");
   a_float: assert property (p_float) else $error("single stuck driving");
   a_mon: assert property (p_mon) else $error("monitor pulse too long");
   a_hold: assert property (p_hold) else $error("divider changed in frame");
   a_ref_only: assert property (p_ref_only) else $error("both dividers moved");
   c_both: cover property ($rose(both_lo));
   c_oe: cover property ($rose(single_ended_error_oe));
   c_ref: cover property ($changed(ref_divide_value));
endmodule : pdoc_monitor
`default_nettype wire

// >>> pdoc_vco_model.sv
`default_nettype none
module pdoc_vco_model (
   // tuning
   input var int half_ns,
   // oscillator pin
   output var logic vco_out
);
   timeunit 1ns;
   timeprecision 100ps;
   // free running like the real oscillator: frames never stop it
   initial begin
      vco_out = 1'b0;
      forever begin
         #(half_ns) vco_out = ~vco_out;
      end
   end
endmodule : pdoc_vco_model
`default_nettype wire

// >>> pdoc_top_bench.sv
`default_nettype none
module pdoc_top_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import pdoc_pkg::*;
   logic mclk, sys_rst, sclk, sdata, ssel_n, xtal, vco, se_out, se_oe, p_ref, p_osc;
   logic ld, ref_o, lvd, rvd, ro_q;
   logic [15:0] nval;
   logic [14:0] rval;
   // set before time zero so the oscillator starts edge-aligned with the crystal
   int vhalf = 100;
   int errors, tests_run, c_osc, c_ref, c_both, c_oelo, c_oehi, c_ldlo, c_rr, c_lv, c_rv;
   int dv[8] = '{0, 1, 2, 4, 8, 16, 8, 16};
   pdoc_top pdoc_top_i (.mclk(mclk), .sys_rst(sys_rst), .serial_clk(sclk),
      .serial_data(sdata), .serial_select_n(ssel_n), .crystal_clock_input(xtal),
      .loop_freq_in(vco), .single_ended_error_out(se_out), .single_ended_error_oe(se_oe),
      .pair_ref_n(p_ref), .pair_osc_n(p_osc), .lock_indicator(ld), .reference_output(ref_o),
      .loop_divided_out(lvd), .reference_divided_out(rvd), .osc_divide_value(nval),
      .ref_divide_value(rval));
   pdoc_vco_model pdoc_vco_model_i (.half_ns(vhalf), .vco_out(vco));
   // ==========================================
   // tasks
   task tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : tick
   task send(input logic [23:0] v, input int n);
      ssel_n = 1'b0;
      tick(4);
      for (int i = n - 1; i >= 0; i--) begin
         sdata = v[i];
         tick(4);
         sclk = 1'b1;
         tick(4);
         sclk = 1'b0;
      end
      tick(4);
      ssel_n = 1'b1;
      tick(12);
   endtask : send
   task wr_cfg(input logic [7:0] v); send({16'h0000, v}, 8); endtask : wr_cfg
   task wr_osc(input logic [15:0] v); send({8'h00, v}, 16); endtask : wr_osc
   task wr_ref(input logic [14:0] v); send({9'h000, v}, 15); endtask : wr_ref
   task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task meas(input int n);
      {c_osc, c_ref, c_both, c_oelo, c_oehi, c_ldlo, c_rr, c_lv, c_rv} = '0;
      repeat (n) begin
         ro_q = ref_o;
         tick(1);
         c_osc += int'(!p_osc && p_ref);
         c_ref += int'(!p_ref && p_osc);
         c_both += int'(!p_osc && !p_ref);
         c_oelo += int'(se_oe && !se_out);
         c_oehi += int'(se_oe && se_out);
         c_ldlo += int'(!ld);
         c_rr += int'(ref_o && !ro_q);
         c_lv += int'(lvd);
         c_rv += int'(rvd);
      end
   endtask : meas
   // a new oscillator divide value jam-loads both counters, so every case starts aligned
   task run(input logic [7:0] cfg, input int half);
      vhalf = half;
      wr_cfg(cfg);
      wr_osc(16'h0028);
      meas(3000);
   endtask : run
   task final_report;
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : final_report
   // ==========================================
   // stimulus
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   initial begin
      xtal = 1'b0;
      forever #100 xtal = ~xtal;
   end
   initial begin
      #2_000_000;
      errors++;
      final_report;
   end
   initial begin
      {sclk, sdata, errors, tests_run} = '0;
      {sys_rst, ssel_n, vhalf} = {1'b1, 1'b1, 32'd100};
      repeat (16) @(posedge mclk);
      #1 sys_rst = 1'b0;
      tick(2);
      chk("osc_div", NDIV_RESET, nval);
      meas(512);
      chk("ref_out_div8", 1, 16'(c_rr >= 7 && c_rr <= 9));
      chk("lock_static_low", 512, 16'(c_ldlo));
      chk("monitor_low", 0, 16'(c_lv + c_rv + c_oelo + c_oehi));
      $display("test reset done");
      for (int s = 0; s < 8; s++) begin
         wr_cfg({3'b000, 3'(s), 2'b00});
         meas(512);
         chk("ref_out_edges", 1, 16'(c_rr >= (dv[s] == 0 ? 0 : 64 / dv[s] - 1)
            && c_rr <= (dv[s] == 0 ? 0 : 64 / dv[s] + 1)));
      end
      chk("osc_kept", NDIV_RESET, nval);
      $display("test reference output done");
      wr_ref(15'h0028);
      chk("ref_div", 16'h0028, {1'b0, rval});
      chk("osc_kept", NDIV_RESET, nval);
      wr_osc(16'h0031);
      chk("osc_div", 16'h0031, nval);
      chk("ref_kept", 16'h0028, {1'b0, rval});
      $display("test dividers done");
      run(8'h50, 100);
      chk("single_float_lock", 0, 16'(c_oelo + c_oehi + c_osc + c_ref + c_both));
      run(8'h30, 100);
      chk("pair_lock", 0, 16'(c_osc + c_ref + c_oelo + c_oehi));
      chk("pair_overlap", 1, 16'(c_both > 0 && c_ldlo < 300));
      run(8'h33, 95);
      chk("pair_lead", 1, 16'(c_osc > 0 && c_ref == 0 && c_ldlo > 0 && c_lv > 0));
      chk("ref_monitor_on", 1, 16'(c_rv > 0));
      run(8'hB0, 95);
      chk("pair_swap", 1, 16'(c_ref > 0 && c_osc == 0));
      run(8'h30, 105);
      chk("pair_lag", 1, 16'(c_ref > 0 && c_osc == 0 && c_oelo + c_oehi == 0));
      run(8'h50, 95);
      chk("single_sink", 1, 16'(c_oelo > 0 && c_oehi == 0 && c_ldlo == 3000));
      chk("pair_parked", 0, 16'(c_osc + c_ref + c_both + c_lv + c_rv));
      run(8'hD0, 95);
      chk("single_invert", 1, 16'(c_oehi > 0 && c_oelo == 0));
      run(8'h50, 105);
      chk("single_source", 1, 16'(c_oehi > 0 && c_oelo == 0));
      $display("test detectors done");
      final_report;
   end
endmodule : pdoc_top_bench
bind pdoc_top pdoc_monitor pdoc_monitor_i (.mclk(mclk), .sys_rst(sys_rst),
   .serial_select_n(serial_select_n), .single_ended_error_oe(single_ended_error_oe),
   .pair_ref_n(pair_ref_n), .pair_osc_n(pair_osc_n), .lock_indicator(lock_indicator),
   .loop_divided_out(loop_divided_out), .osc_divide_value(osc_divide_value),
   .ref_divide_value(ref_divide_value));
`default_nettype wire
